/* File: design/tps_pkg.sv */
// shared constants of the two-port 512x18 memory block
package tps_pkg;
   localparam int DATA_W = 18;
   localparam int HALF_W = 9;
   localparam int ADDR_W = 9;
   localparam int ROW_W = 8;
   localparam int ROWS = 256;
   localparam int SYNC_W = 3;
   localparam logic [1:0] GEOM_NARROW = 2'h1;
   localparam logic [1:0] GEOM_WIDE = 2'h2;
   localparam logic [17:0] DATA_RST = 18'h0_0000;
   localparam logic [8:0] HALF_ZERO = 9'h000;
   localparam logic [2:0] SYNC_RST = 3'h0;
   localparam logic [1:0] HALF_NONE = 2'h0;
   localparam logic [1:0] HALF_LOW = 2'h1;
   localparam logic [1:0] HALF_HIGH = 2'h2;
   localparam logic [1:0] HALF_BOTH = 2'h3;
endpackage : tps_pkg

/* File: design/tps_mem_array.sv */
// storage array: 256 rows of two 9-bit halves, no reset on contents
module tps_mem_array
(
   input wire logic ref_clk,
   input wire logic [tps_pkg::ROW_W-1:0] rowWrite,
   input wire logic [1:0] halfWe,
   input wire logic [tps_pkg::DATA_W-1:0] wrWord,
   input wire logic [tps_pkg::ROW_W-1:0] rowRead,
   output logic [tps_pkg::DATA_W-1:0] rdWord
);

   // ----------------------------------------
   // one bank per half word
   // ----------------------------------------
   genvar h;
   generate
      for (h = 0; h < 2; h++)
      begin : g_bank
         logic [tps_pkg::HALF_W-1:0] bank [0:tps_pkg::ROWS-1];
         always_ff @(posedge ref_clk)
         begin
            if (halfWe[h])
            begin
               bank[rowWrite] <= wrWord[h*tps_pkg::HALF_W +: tps_pkg::HALF_W];
            end
         end
         assign rdWord[h*tps_pkg::HALF_W +: tps_pkg::HALF_W] = bank[rowRead];
      end
   endgenerate

endmodule : tps_mem_array

/* File: design/tps_sram_top.sv */
// two-port memory with separate write and read ports, 512x9 or 256x18 per port
module tps_sram_top
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic portResetN,
   input wire logic writeClk,
   input wire logic writeClkFall,
   input wire logic writeEnable,
   input wire logic writeEnHigh,
   input wire logic [1:0] writeWidthSelect,
   input wire logic [tps_pkg::ADDR_W-1:0] writeAddress,
   input wire logic [tps_pkg::DATA_W-1:0] writeData,
   input wire logic readClk,
   input wire logic readClkFall,
   input wire logic readEnable,
   input wire logic readEnHigh,
   input wire logic [1:0] readWidthSelect,
   input wire logic [tps_pkg::ADDR_W-1:0] readAddress,
   input wire logic pipeSelect,
   output logic [tps_pkg::DATA_W-1:0] readData
);

   // ----------------------------------------
   // pin synchronisers: bit0 write clock, bit1 read clock, bit2 port reset
   // ----------------------------------------
   logic [2:0] pinIn;
   logic [2:0] sync1_r, sync2_r, sync3_r, lvl_r, prevLvl_r;
   logic [2:0] sync1_nxt, sync2_nxt, sync3_nxt, lvl_nxt, prevLvl_nxt;

   assign pinIn = {portResetN, readClk, writeClk};

   always_comb
   begin
      sync1_nxt = pinIn;
      sync2_nxt = sync1_r;
      sync3_nxt = sync2_r;
      // a level change counts once stages two and three agree
      lvl_nxt = ((sync2_r ~^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & lvl_r);
      prevLvl_nxt = lvl_r;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sync1_r <= tps_pkg::SYNC_RST;
         sync2_r <= tps_pkg::SYNC_RST;
         sync3_r <= tps_pkg::SYNC_RST;
         lvl_r <= tps_pkg::SYNC_RST;
         prevLvl_r <= tps_pkg::SYNC_RST;
      end
      else
      begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         sync3_r <= sync3_nxt;
         lvl_r <= lvl_nxt;
         prevLvl_r <= prevLvl_nxt;
      end
   end

   // ----------------------------------------
   // port strobes and clear
   // ----------------------------------------
   logic wrStrobe, rdStrobe, clr;

   // strobe on the chosen edge of each port clock
   assign wrStrobe = (lvl_r[0] ^ prevLvl_r[0]) & (lvl_r[0] ^ writeClkFall);
   assign rdStrobe = (lvl_r[1] ^ prevLvl_r[1]) & (lvl_r[1] ^ readClkFall);
   assign clr = ~lvl_r[2];

   // ----------------------------------------
   // write port
   // ----------------------------------------
   logic wrEnOn, wrNarrow, wrWide;
   logic [1:0] halfWe;
   logic [tps_pkg::DATA_W-1:0] wrWord;

   always_comb
   begin
      wrEnOn = (writeEnable == writeEnHigh);
      wrNarrow = (writeWidthSelect == tps_pkg::GEOM_NARROW);
      wrWide = (writeWidthSelect == tps_pkg::GEOM_WIDE);
      halfWe = tps_pkg::HALF_NONE;
      if (wrStrobe && wrEnOn && !clr)
      begin
         if (wrWide)
         begin
            halfWe = tps_pkg::HALF_BOTH;
         end
         else if (wrNarrow)
         begin
            halfWe = writeAddress[8] ? tps_pkg::HALF_HIGH : tps_pkg::HALF_LOW;
         end
      end
      // narrow data lands in whichever half is addressed
      wrWord = wrWide ? writeData : {writeData[8:0], writeData[8:0]};
   end

   logic [tps_pkg::DATA_W-1:0] rdWord;

   // separate write and read rows, both usable in one cycle
   tps_mem_array u_mem
   (
      .ref_clk(ref_clk),
      .rowWrite(writeAddress[7:0]),
      .halfWe(halfWe),
      .wrWord(wrWord),
      .rowRead(readAddress[7:0]),
      .rdWord(rdWord)
   );

   // ----------------------------------------
   // read port, hold and output registers
   // ----------------------------------------
   logic rdEnOn, rdNarrow, rdWide, rdAct;
   logic [tps_pkg::DATA_W-1:0] rdSel;
   logic [tps_pkg::DATA_W-1:0] hold_r, hold_nxt, readData_r, readData_nxt;

   always_comb
   begin
      rdEnOn = (readEnable == readEnHigh);
      rdNarrow = (readWidthSelect == tps_pkg::GEOM_NARROW);
      rdWide = (readWidthSelect == tps_pkg::GEOM_WIDE);
      rdAct = rdStrobe && rdEnOn && (rdNarrow || rdWide) && !clr;
      // undefined upper bits of a narrow read are driven as zero
      rdSel = rdWide ? rdWord : {tps_pkg::HALF_ZERO, (readAddress[8] ? rdWord[17:9] : rdWord[8:0])};
      hold_nxt = hold_r;
      readData_nxt = readData_r;
      if (clr)
      begin
         hold_nxt = tps_pkg::DATA_RST;
         readData_nxt = tps_pkg::DATA_RST;
      end
      else if (rdStrobe)
      begin
         if (rdAct)
         begin
            hold_nxt = rdSel;
         end
         if (pipeSelect)
         begin
            readData_nxt = hold_r;
         end
         else
         begin
            readData_nxt = rdAct ? rdSel : hold_r;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         hold_r <= tps_pkg::DATA_RST;
         readData_r <= tps_pkg::DATA_RST;
      end
      else
      begin
         hold_r <= hold_nxt;
         readData_r <= readData_nxt;
      end
   end

   assign readData = readData_r;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_direct_read;
      rdAct && !pipeSelect;
   endsequence

   sequence s_pipe_load;
      rdAct && pipeSelect;
   endsequence

   sequence s_pipe_shift;
      rdStrobe && pipeSelect && !clr;
   endsequence

   a_clear_zeroes_out: assert property (clr |=> readData == tps_pkg::DATA_RST)
      else $error("output not zero during port reset");
   a_clear_blocks_write: assert property (clr |-> halfWe == tps_pkg::HALF_NONE)
      else $error("write happened during port reset");
   a_clear_keeps_mem: assert property ((clr ##1 (clr && $stable(readAddress))) |-> $stable(rdWord))
      else $error("memory changed during port reset");
   a_wide_write_both: assert property ((wrStrobe && wrEnOn && !clr && wrWide) |-> halfWe == tps_pkg::HALF_BOTH)
      else $error("wide write did not fill both halves");
   a_narrow_write_half: assert property ((wrStrobe && wrEnOn && !clr && wrNarrow) |->
      halfWe == (writeAddress[8] ? tps_pkg::HALF_HIGH : tps_pkg::HALF_LOW))
      else $error("narrow write picked the wrong half");
   a_reserved_write_off: assert property ((!wrNarrow && !wrWide) |-> halfWe == tps_pkg::HALF_NONE)
      else $error("reserved width code wrote memory");
   a_write_enable_pol: assert property ((writeEnable != writeEnHigh) |-> halfWe == tps_pkg::HALF_NONE)
      else $error("write with enable inactive");
   a_direct_read_data: assert property (s_direct_read |=> readData == $past(rdSel))
      else $error("direct read data not presented");
   a_narrow_upper_zero: assert property ((rdAct && !pipeSelect && rdNarrow) |=> readData[17:9] == tps_pkg::HALF_ZERO)
      else $error("narrow read upper bits not zero");
   a_pipe_hold_load: assert property (s_pipe_load |=> hold_r == $past(rdSel))
      else $error("pipelined read not captured");
   a_pipe_out_shift: assert property (s_pipe_shift |=> readData == $past(hold_r))
      else $error("pipelined output not one read clock late");
   a_write_edge_sense: assert property (($changed(lvl_r[0]) && (lvl_r[0] != writeClkFall)) |-> wrStrobe)
      else $error("write strobe missed on chosen edge");
   a_read_edge_sense: assert property ((rdStrobe) |-> ($past(lvl_r[1]) != lvl_r[1]) && (lvl_r[1] == !readClkFall))
      else $error("read strobe on wrong edge");

endmodule : tps_sram_top

/* File: verification/tps_fabric_model.sv */
// fabric-side model that makes the write and read port clock pulses
module tps_fabric_model
(
   input wire logic ref_clk,
   input wire logic wrGo,
   input wire logic rdGo,
   output logic writeClk,
   output logic readClk,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   initial
   begin
      cnt = 4'h0;
      writeClk = 1'h0;
      readClk = 1'h0;
   end
   // clocks idle low; high level held 7 cycles, low at least 6, so both edge senses see stable inputs
   always @(posedge ref_clk)
   begin
      if (cnt == 4'h0)
      begin
         if (wrGo || rdGo)
         begin
            cnt <= 4'hc;
            writeClk <= wrGo;
            readClk <= rdGo;
         end
      end
      else
      begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h6)
         begin
            writeClk <= 1'h0;
            readClk <= 1'h0;
         end
      end
   end
   assign busy = (cnt != 4'h0);
endmodule : tps_fabric_model

/* File: verification/tb_two_port_sram_512x18.sv */
// self-checking bench of the two-port memory
module tb_two_port_sram_512x18;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [1:0] ww; logic [8:0] wa; logic [17:0] wd; logic we; logic weh;
      logic [1:0] rw; logic [8:0] ra; logic fall; logic [17:0] exp;} tps_row_t;
   logic ref_clk, reset, portResetN, writeClk, writeClkFall, writeEnable, writeEnHigh;
   logic readClk, readClkFall, readEnable, readEnHigh, pipeSelect, wrGo, rdGo, busy;
   logic [1:0] writeWidthSelect, readWidthSelect;
   logic [8:0] writeAddress, readAddress;
   logic [17:0] writeData, readData;
   logic [17:0] rdMask;
   int fail_count = 0;
   int cmp_count = 0;
   tps_row_t rows [6];
   tps_sram_top uut (.ref_clk(ref_clk), .reset(reset), .portResetN(portResetN), .writeClk(writeClk),
      .writeClkFall(writeClkFall), .writeEnable(writeEnable), .writeEnHigh(writeEnHigh),
      .writeWidthSelect(writeWidthSelect), .writeAddress(writeAddress), .writeData(writeData),
      .readClk(readClk), .readClkFall(readClkFall), .readEnable(readEnable), .readEnHigh(readEnHigh),
      .readWidthSelect(readWidthSelect), .readAddress(readAddress), .pipeSelect(pipeSelect),
      .readData(readData));
   tps_fabric_model fab (.ref_clk(ref_clk), .wrGo(wrGo), .rdGo(rdGo), .writeClk(writeClk),
      .readClk(readClk), .busy(busy));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      cmp_count++;
      if (seen !== exp)
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      if (seen !== exp)
         fail_count++;
   endtask : check
   task automatic op(input logic w, input logic r);
      int n;
      @(negedge ref_clk);
      wrGo = w;
      rdGo = r;
      @(negedge ref_clk);
      wrGo = 1'h0;
      rdGo = 1'h0;
      n = 0;
      while (busy === 1'h1 && n < 40)
      begin
         @(negedge ref_clk);
         n++;
      end
      repeat (2) @(negedge ref_clk);
   endtask : op
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      fail_count++;
      report_and_stop();
   end
   initial
   begin
      {reset, portResetN, wrGo, rdGo, pipeSelect} = 5'h18;
      {writeClkFall, writeEnable, writeEnHigh, readClkFall, readEnable, readEnHigh} = 6'h12;
      {writeWidthSelect, readWidthSelect, writeAddress, readAddress, writeData} = '0;
      // narrow writes keep data[17:9] zero, wide addresses keep bit 8 zero
      rows = '{'{tps_pkg::GEOM_WIDE, 9'h005, 18'h2_a5a5, 1'h0, 1'h0, tps_pkg::GEOM_WIDE, 9'h005, 1'h0, 18'h2_a5a5},
         '{tps_pkg::GEOM_NARROW, 9'h105, 18'h0_0133, 1'h1, 1'h1, tps_pkg::GEOM_WIDE, 9'h005, 1'h1, 18'h2_67a5},
         '{2'h0, 9'h005, 18'h3_ffff, 1'h0, 1'h0, tps_pkg::GEOM_NARROW, 9'h105, 1'h0, 18'h0_0133},
         '{tps_pkg::GEOM_WIDE, 9'h005, 18'h1_ffff, 1'h1, 1'h0, tps_pkg::GEOM_NARROW, 9'h005, 1'h1, 18'h0_01a5},
         '{tps_pkg::GEOM_WIDE, 9'h0ff, 18'h3_c3c3, 1'h0, 1'h0, tps_pkg::GEOM_WIDE, 9'h0ff, 1'h0, 18'h3_c3c3},
         '{2'h3, 9'h0ff, 18'h0_0000, 1'h0, 1'h0, tps_pkg::GEOM_NARROW, 9'h1ff, 1'h0, 18'h0_01e1}};
      repeat (10) @(negedge ref_clk);
      reset = 1'h0;
      repeat (10) @(negedge ref_clk);
      check(readData, 18'h0_0000);
      $display("reset test done");
      for (int i = 0; i < 6; i++)
      begin
         {writeWidthSelect, writeAddress, writeData} = {rows[i].ww, rows[i].wa, rows[i].wd};
         {writeEnable, writeEnHigh, writeClkFall, readClkFall} = {rows[i].we, rows[i].weh, {2{rows[i].fall}}};
         op(1'h1, 1'h0);
         {readWidthSelect, readAddress, readEnable, readEnHigh} = {rows[i].rw, rows[i].ra, {2{rows[i].weh}}};
         op(1'h0, 1'h1);
         rdMask = (rows[i].rw == tps_pkg::GEOM_NARROW) ? 18'h0_01ff : 18'h3_ffff;
         check(readData & rdMask, rows[i].exp);
         $display("row %0d done", i);
      end
      // write one row while reading another, both port clocks pulsed together
      {writeWidthSelect, readWidthSelect, writeEnable, readEnable} = {tps_pkg::GEOM_WIDE, tps_pkg::GEOM_WIDE, 2'h0};
      {writeAddress, writeData, readAddress} = {9'h0ff, 18'h1_2345, 9'h005};
      // write on falling edges, read on rising edges
      {writeClkFall, readClkFall} = 2'h2;
      op(1'h1, 1'h1);
      check(readData, 18'h2_67a5);
      readAddress = 9'h0ff;
      op(1'h0, 1'h1);
      check(readData, 18'h1_2345);
      $display("concurrent test done");
      pipeSelect = 1'h1;
      readAddress = 9'h005;
      op(1'h0, 1'h1);
      readAddress = 9'h0ff;
      op(1'h0, 1'h1);
      check(readData, 18'h2_67a5);
      op(1'h0, 1'h1);
      check(readData, 18'h1_2345);
      pipeSelect = 1'h0;
      $display("pipeline test done");
      portResetN = 1'h0;
      repeat (8) @(negedge ref_clk);
      check(readData, 18'h0_0000);
      {writeAddress, writeData} = {9'h005, 18'h0_0000};
      op(1'h1, 1'h0);
      portResetN = 1'h1;
      repeat (10) @(negedge ref_clk);
      readAddress = 9'h005;
      op(1'h0, 1'h1);
      check(readData, 18'h2_67a5);
      $display("port reset test done");
      report_and_stop();
   end
endmodule : tb_two_port_sram_512x18
